/* File: ssf_pkg.sv */
// constants, register map and state carrier of the spi status flag block
// assumes one bus clock domain; link pins are sampled, not clocked
package ssf_pkg;
  // ==========================================================
  // register map (byte offsets on the register port)
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_STAT = 3'h3;
  localparam logic [2:0] ADDR_DATA = 3'h5;
  localparam logic [2:0] ADDR_MATCH = 3'h7;
  // ==========================================================
  // field positions
  localparam int STAT_RXF = 7;
  localparam int STAT_MATCH = 6;
  localparam int STAT_TXE = 5;
  localparam int STAT_FAULT = 4;
  localparam int CTRL_MASTER_SELECT = 4;
  localparam int CTRL_SOE = 1;
  localparam int CTRL_FDE = 0;
  // ==========================================================
  // link sampling: bit order of the synchroniser vectors
  localparam int LNK_SCK = 0;
  localparam int LNK_SS = 1;
  localparam int LNK_SDI = 2;
  localparam logic [2:0] LNK_RST = 3'h2;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // ==========================================================
  // whole block state
  typedef struct packed {
    logic master_select;
    logic fault_detect_enable;
    logic select_output_enable;
    logic [7:0] match_val;
    logic [7:0] rx_data;
    logic rx_full_flag;
    logic rx_match_flag;
    logic master_fault_flag;
    logic rx_arm;
    logic match_arm;
    logic tx_arm;
    logic fault_arm;
    logic [7:0] tx_buf;
    logic tx_pending;
    logic [7:0] txsh;
    logic [7:0] last_tx;
    logic [7:0] rxsh;
    logic [2:0] bit_cnt;
    logic loaded;
    logic just_loaded;
    logic [7:0] rdata;
    logic sdo;
    logic sdo_oe;
    logic ss_n;
    logic ss_oe;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] filt;
    logic [2:0] filt_d;
  } ssf_state_t;
  localparam ssf_state_t ST_RST = '{
    sync1: LNK_RST, sync2: LNK_RST, sync3: LNK_RST,
    filt: LNK_RST, filt_d: LNK_RST, ss_n: 1'b1, default: '0};
endpackage

/* File: ssf_top.sv */
// status flags, transmit queue and shifter of an spi port
// assumes a register port master on clk_in and an spi peer on the pins
//
// Behaviour
// - receive-full flag, bit 7, sets when each byte transfer completes
// - receive-full clears after status read while set, then data read
// - match flag, bit 6, sets when full and received byte equals compare
// - match clears after reading it set, then writing 1 to bit 6
// - transmit-empty flag, bit 5, is 1 while no byte is pending
// - transmit-empty clears on status read while set, then data write
// - data writes without prior status read showing empty are discarded
// - idle port moves written byte to shifter, empty again within two cycles
// - at byte end a queued byte moves into the shifter, empty sets
// - at byte end with nothing queued, flag stays set, last byte reloads into shifter
// - continued shifting without new data resends the last byte
// - master mode: peer select low sets the mode-fault flag, bit 4
// - fault detection only with master, fault enable 1, select output 0
// - mode-fault clears after reading it 1 then writing control register
// - status bits 3 to 0 read zero
// - other writes to status leave every status bit unchanged
// - an 8-bit compare register drives the match flag
// - byte completing while previous unread is dropped, no indication
module ssf_top (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic sck_in,
  input wire logic ss_n_in,
  input wire logic sdi_in,
  output logic [7:0] rdata_out,
  output logic sdo_out,
  output logic sdo_oe_out,
  output logic ss_n_out,
  output logic ss_oe_out
);
  // ==========================================================
  // reset release
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ==========================================================
  // next state
  ssf_pkg::ssf_state_t st;
  ssf_pkg::ssf_state_t next_st;
  logic sck_rise;
  logic sck_fall;
  logic ss_low;
  logic active;
  logic byte_end;
  logic fault_cond;
  logic rd_stat;
  logic rd_data;
  logic wr_stat;
  logic wr_data;
  logic wr_ctrl;
  logic rx_clr;
  logic [7:0] stat_val;
  logic [7:0] ctrl_val;
  logic [7:0] rx_byte;

  always_comb
  begin
    next_st = st;
    next_st.sync1 = {sdi_in, ss_n_in, sck_in};
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    for (int i = 0; i < 3; i++)
    begin
      if (st.sync2[i] == st.sync3[i])
      begin
        next_st.filt[i] = st.sync3[i];
      end
    end
    next_st.filt_d = st.filt;
    sck_rise = st.filt[ssf_pkg::LNK_SCK] & ~st.filt_d[ssf_pkg::LNK_SCK];
    sck_fall = ~st.filt[ssf_pkg::LNK_SCK] & st.filt_d[ssf_pkg::LNK_SCK];
    ss_low = ~st.filt[ssf_pkg::LNK_SS];
    rx_byte = {st.rxsh[6:0], st.filt[ssf_pkg::LNK_SDI]};
    active = st.master_select ? st.loaded : ss_low;
    byte_end = active & sck_rise & (st.bit_cnt == ssf_pkg::LAST_BIT);
    fault_cond = st.master_select & st.fault_detect_enable &
                 ~st.select_output_enable & ss_low;
    rd_stat = rd_in & (addr_in == ssf_pkg::ADDR_STAT);
    rd_data = rd_in & (addr_in == ssf_pkg::ADDR_DATA);
    wr_stat = wr_in & (addr_in == ssf_pkg::ADDR_STAT);
    wr_data = wr_in & (addr_in == ssf_pkg::ADDR_DATA);
    wr_ctrl = wr_in & (addr_in == ssf_pkg::ADDR_CTRL);
    rx_clr = rd_data & st.rx_arm & st.rx_full_flag;
    // status bits 3..0 stay zero
    stat_val = 8'h00;
    stat_val[ssf_pkg::STAT_RXF] = st.rx_full_flag;
    stat_val[ssf_pkg::STAT_MATCH] = st.rx_match_flag;
    stat_val[ssf_pkg::STAT_TXE] = ~st.tx_pending;
    stat_val[ssf_pkg::STAT_FAULT] = st.master_fault_flag;
    ctrl_val = 8'h00;
    ctrl_val[ssf_pkg::CTRL_MASTER_SELECT] = st.master_select;
    ctrl_val[ssf_pkg::CTRL_SOE] = st.select_output_enable;
    ctrl_val[ssf_pkg::CTRL_FDE] = st.fault_detect_enable;
    // register reads, data valid the cycle after the strobe only
    next_st.rdata = 8'h00;
    if (rd_in)
    begin
      case (addr_in)
        ssf_pkg::ADDR_CTRL: next_st.rdata = ctrl_val;
        ssf_pkg::ADDR_STAT: next_st.rdata = stat_val;
        ssf_pkg::ADDR_DATA: next_st.rdata = st.rx_data;
        ssf_pkg::ADDR_MATCH: next_st.rdata = st.match_val;
        default: next_st.rdata = 8'h00;
      endcase
    end
    // status read arms the clearing sequences
    if (rd_stat)
    begin
      next_st.rx_arm = st.rx_full_flag;
      next_st.match_arm = st.rx_match_flag;
      next_st.tx_arm = ~st.tx_pending;
      next_st.fault_arm = st.master_fault_flag;
    end
    if (rx_clr)
    begin
      next_st.rx_full_flag = 1'b0;
      next_st.rx_arm = 1'b0;
    end
    // status writes only act through the match clear
    if (wr_stat & st.match_arm & wdata_in[ssf_pkg::STAT_MATCH])
    begin
      next_st.rx_match_flag = 1'b0;
      next_st.match_arm = 1'b0;
    end
    if (wr_ctrl)
    begin
      next_st.master_select = wdata_in[ssf_pkg::CTRL_MASTER_SELECT];
      next_st.select_output_enable = wdata_in[ssf_pkg::CTRL_SOE];
      next_st.fault_detect_enable = wdata_in[ssf_pkg::CTRL_FDE];
      if (st.fault_arm)
      begin
        next_st.master_fault_flag = 1'b0;
        next_st.fault_arm = 1'b0;
      end
    end
    if (wr_in & (addr_in == ssf_pkg::ADDR_MATCH))
    begin
      next_st.match_val = wdata_in;
    end
    if (wr_data)
    begin
      if (st.tx_arm)
      begin
        next_st.tx_buf = wdata_in;
        next_st.tx_pending = 1'b1;
      end
      next_st.tx_arm = 1'b0;
    end
    // shifter
    if (!active)
    begin
      next_st.bit_cnt = 3'h0;
    end
    else if (sck_rise)
    begin
      next_st.rxsh = rx_byte;
      next_st.bit_cnt = st.bit_cnt + 3'h1;
    end
    else if (sck_fall)
    begin
      if (st.just_loaded)
      begin
        next_st.just_loaded = 1'b0;
      end
      else
      begin
        next_st.txsh = {st.txsh[6:0], 1'b0};
      end
    end
    if (byte_end)
    begin
      if (!st.rx_full_flag || rx_clr)
      begin
        next_st.rx_data = rx_byte;
        next_st.rx_full_flag = 1'b1;
      end
      next_st.just_loaded = 1'b1;
      if (st.tx_pending)
      begin
        next_st.txsh = st.tx_buf;
        next_st.last_tx = st.tx_buf;
        next_st.tx_pending = 1'b0;
        next_st.loaded = 1'b1;
      end
      else
      begin
        next_st.txsh = st.last_tx;
        next_st.loaded = 1'b0;
      end
    end
    else if (!st.loaded && st.tx_pending && st.bit_cnt == 3'h0)
    begin
      next_st.txsh = st.tx_buf;
      next_st.last_tx = st.tx_buf;
      next_st.tx_pending = 1'b0;
      next_st.loaded = 1'b1;
    end
    // mode fault drops to slave and aborts the transfer
    if (fault_cond)
    begin
      next_st.master_fault_flag = 1'b1;
      next_st.master_select = 1'b0;
      next_st.loaded = 1'b0;
      next_st.bit_cnt = 3'h0;
    end
    if (st.rx_full_flag && st.rx_data == st.match_val)
    begin
      next_st.rx_match_flag = 1'b1;
    end
    // pins
    next_st.sdo = next_st.txsh[7];
    next_st.sdo_oe = st.master_select ? st.loaded : ss_low;
    next_st.ss_oe = st.master_select & st.fault_detect_enable &
                    st.select_output_enable;
    next_st.ss_n = ~(st.master_select & st.loaded);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= ssf_pkg::ST_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rdata_out = st.rdata;
  assign sdo_out = st.sdo;
  assign sdo_oe_out = st.sdo_oe;
  assign ss_n_out = st.ss_n;
  assign ss_oe_out = st.ss_oe;

  // ==========================================================
  // checks
  stat_low_zero_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    rd_stat |=> (rdata_out[3:0] == 4'h0))
    else $error("status low bits not zero");
  rx_full_set_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (byte_end && !st.rx_full_flag) |=> st.rx_full_flag)
    else $error("receive full not set at byte end");
  rx_full_clr_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (rx_clr && !byte_end) |=> !st.rx_full_flag)
    else $error("receive full not cleared");
  match_set_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (st.rx_full_flag && st.rx_data == st.match_val) |=> st.rx_match_flag)
    else $error("match flag not set");
  write_drop_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (wr_data && !st.tx_arm && !st.tx_pending) |=> !st.tx_pending)
    else $error("unarmed data write accepted");
  idle_load_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (wr_data && st.tx_arm && !st.loaded && st.bit_cnt == 3'h0)
    |-> ##[1:2] !st.tx_pending)
    else $error("idle byte not moved to shifter");
  fault_set_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    fault_cond |=> (st.master_fault_flag && !st.master_select))
    else $error("mode fault not flagged");
  fault_gate_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (!(st.master_select && st.fault_detect_enable &&
       !st.select_output_enable) && !st.master_fault_flag)
    |=> !st.master_fault_flag)
    else $error("mode fault set while detection off");
  stat_write_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (wr_stat && !fault_cond) |=>
    (st.master_fault_flag == $past(st.master_fault_flag)))
    else $error("status write changed fault flag");
  overrun_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (byte_end && st.rx_full_flag && !rx_clr) |=> $stable(st.rx_data))
    else $error("unread byte overwritten");
endmodule

/* File: ssf_peer.sv */
// remote spi master model driving the link pins of the block
// assumes mode 0, msb first, 160 ns sck period, called by the bench
module ssf_peer (
  input wire logic sdo_in,
  output logic sck_out,
  output logic ss_n_out,
  output logic sdi_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // idle levels
  initial
  begin
    sck_out = 1'b0;
    ss_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // ==========================================================
  // select level alone, for the fault checks
  task automatic sel(input logic v);
    // keeps pin changes off the bus clock edge
    #5;
    ss_n_out = v;
    #400;
  endtask
  // one framed byte; sck stands low outside the frame
  // the block's pin sampling delays its data by several bus clocks,
  // so the returned bit is read late in each high phase
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #5;
    ss_n_out = 1'b0;
    #160;
    for (int i = 7; i >= 0; i--)
    begin
      sdi_out = tx[i];
      #80 sck_out = 1'b1;
      #70 rx[i] = sdo_in;
      #10 sck_out = 1'b0;
    end
    #160 ss_n_out = 1'b1;
    // released line shows no stale level
    sdi_out = ~sdi_out;
    #400;
  endtask
endmodule

/* File: spi_status_flags_bench.sv */
// self-checking bench of the spi status flag block
// assumes ssf_pkg, ssf_top and ssf_peer; block runs as slave to the peer, as master in the fault test
module spi_status_flags_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic sck, ss_n, sdi, sdo;
  logic [7:0] rdata_out;
  logic ss_oe_out;
  logic sdo_oe_out;
  logic ss_n_out;
  logic [7:0] got;
  int err_total = 0;
  int tests_run = 0;
  // ==========================================================
  // clock, design and peer
  always #10 clk_in = ~clk_in;
  ssf_top ssf_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .sck_in(sck), .ss_n_in(ss_n), .sdi_in(sdi), .rdata_out(rdata_out),
    .sdo_out(sdo), .sdo_oe_out(sdo_oe_out), .ss_n_out(ss_n_out),
    .ss_oe_out(ss_oe_out));
  ssf_peer ssf_peer_inst (.sdo_in(sdo), .sck_out(sck), .ss_n_out(ss_n),
    .sdi_out(sdi));
  // ==========================================================
  // compare, bus cycles, end of run
  task automatic cmp(input string n, input logic [7:0] e,
    input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [2:0] a,
    input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    cmp(n, e, rdata_out);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_tx;
    cmp("data oe", 8'h00, {7'h00, sdo_oe_out});
    wr(ssf_pkg::ADDR_DATA, 8'ha5);
    rdc("status", ssf_pkg::ADDR_STAT, 8'h20);
    rdc("unmapped", 3'h1, 8'h00);
    wr(ssf_pkg::ADDR_DATA, 8'h3c);
    rdc("status", ssf_pkg::ADDR_STAT, 8'h20);
    wr(ssf_pkg::ADDR_DATA, 8'h5a);
    rdc("status", ssf_pkg::ADDR_STAT, 8'h00);
    ssf_peer_inst.xfer(8'h11, got);
    cmp("peer byte", 8'h3c, got);
    rdc("status", ssf_pkg::ADDR_STAT, 8'ha0);
    rdc("data", ssf_pkg::ADDR_DATA, 8'h11);
    rdc("status", ssf_pkg::ADDR_STAT, 8'h20);
    ssf_peer_inst.xfer(8'h22, got);
    cmp("peer byte", 8'h5a, got);
    rdc("status", ssf_pkg::ADDR_STAT, 8'ha0);
    rdc("data", ssf_pkg::ADDR_DATA, 8'h22);
    ssf_peer_inst.xfer(8'h33, got);
    cmp("peer byte", 8'h5a, got);
    rdc("status", ssf_pkg::ADDR_STAT, 8'ha0);
    rdc("data", ssf_pkg::ADDR_DATA, 8'h33);
    $display("test transmit done");
  endtask
  task automatic t_rx;
    wr(ssf_pkg::ADDR_MATCH, 8'h81);
    ssf_peer_inst.xfer(8'h81, got);
    rdc("status", ssf_pkg::ADDR_STAT, 8'he0);
    ssf_peer_inst.xfer(8'h44, got);
    rdc("data", ssf_pkg::ADDR_DATA, 8'h81);
    rdc("status", ssf_pkg::ADDR_STAT, 8'h60);
    wr(ssf_pkg::ADDR_STAT, 8'hbf);
    rdc("status", ssf_pkg::ADDR_STAT, 8'h60);
    wr(ssf_pkg::ADDR_STAT, 8'h40);
    rdc("status", ssf_pkg::ADDR_STAT, 8'h20);
    $display("test receive done");
  endtask
  task automatic t_fault;
    wr(ssf_pkg::ADDR_CTRL, 8'h13);
    rdc("status", ssf_pkg::ADDR_STAT, 8'h20);
    wr(ssf_pkg::ADDR_DATA, 8'h96);
    ssf_peer_inst.sel(1'b0);
    rdc("status", ssf_pkg::ADDR_STAT, 8'h20);
    cmp("select oe", 8'h01, {7'h00, ss_oe_out});
    cmp("select out", 8'h00, {7'h00, ss_n_out});
    cmp("data oe", 8'h01, {7'h00, sdo_oe_out});
    ssf_peer_inst.sel(1'b1);
    wr(ssf_pkg::ADDR_CTRL, 8'h11);
    ssf_peer_inst.sel(1'b0);
    rdc("status", ssf_pkg::ADDR_STAT, 8'h30);
    cmp("select out", 8'h01, {7'h00, ss_n_out});
    ssf_peer_inst.sel(1'b1);
    wr(ssf_pkg::ADDR_CTRL, 8'h00);
    rdc("status", ssf_pkg::ADDR_STAT, 8'h20);
    $display("test fault done");
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_tx();
    t_rx();
    t_fault();
    conclude();
  end
  initial
  begin
    #200000;
    err_total++;
    conclude();
  end
endmodule
